// ### wcp_pkg.sv
// Package: register map, field layout and timing for the wetting/pulse bank
package wcp_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0]  WC_SELECT_HI_IDX  = 8'h1e;
  localparam logic [7:0]  PULSE_CFG_IDX     = 8'h1f;
  localparam logic [7:0]  PULSE_EN_IDX      = 8'h20;
  localparam logic [9:0]  WC_SELECT_HI_ADDR = {WC_SELECT_HI_IDX, 2'b00};
  localparam logic [9:0]  PULSE_CFG_ADDR    = {PULSE_CFG_IDX, 2'b00};
  localparam logic [9:0]  PULSE_EN_ADDR     = {PULSE_EN_IDX, 2'b00};
  localparam int          ADDR_W            = 10;
  localparam int          REG_W             = 24;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int          CODE_W            = 3;
  localparam int          NUM_PAIRS         = 4;
  localparam int          NUM_GROUPS        = 4;
  localparam int          NUM_INPUTS        = 24;
  localparam int          GROUP_SIZE        = 6;
  localparam int          FIRST_PAIR_INPUT  = 12;
  localparam int          WC_USED_W         = 12;
  localparam int          DUR_LSB           = 4;
  localparam int          DUR_MSB           = 6;
  localparam int          LEVEL_LSB         = 0;
  localparam logic [23:0] WC_WRITE_MASK     = 24'h00_0fff;
  localparam logic [23:0] PULSE_CFG_MASK    = 24'h00_007f;
  localparam logic [23:0] PULSE_EN_MASK     = 24'hff_ffff;
  localparam logic [23:0] REG_RESET         = 24'h00_0000;

  // ----------------------------------------------------------------------
  // Current encodings (typical mA)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  MA_NONE = 4'h0;
  localparam logic [3:0]  MA_1    = 4'h1;
  localparam logic [3:0]  MA_2    = 4'h2;
  localparam logic [3:0]  MA_5    = 4'h5;
  localparam logic [3:0]  MA_10   = 4'ha;
  localparam logic [3:0]  MA_15   = 4'hf;
  localparam logic [2:0]  CODE_1  = 3'h1;
  localparam logic [2:0]  CODE_2  = 3'h2;
  localparam logic [2:0]  CODE_3  = 3'h3;
  localparam logic [2:0]  CODE_4  = 3'h4;
  localparam logic [2:0]  CODE_0  = 3'h0;

  // ----------------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          PULSE_STEP_US  = 64;
  localparam int          STEP_CYCLES    = (PULSE_STEP_US * CLK_HZ) / 1_000_000;
  localparam int          CNT_W          = 14;
  localparam int          PULSE_PERIOD_W = 24;

endpackage

// ### wcp_current_decode.sv
// Decoder from a 3-bit wetting current code to a current level
`timescale 1ns/1ps
`default_nettype none

module wcp_current_decode
  import wcp_pkg::*;
(
  // Code in
  input  wire logic [2:0] code,
  // Level out
  output logic      [3:0] level_ma
);

  always_comb
  begin
    unique case (code)
      CODE_0:  level_ma = MA_NONE;
      CODE_1:  level_ma = MA_1;
      CODE_2:  level_ma = MA_2;
      CODE_3:  level_ma = MA_5;
      CODE_4:  level_ma = MA_10;
      default: level_ma = MA_15;
    endcase
  end

endmodule

`default_nettype wire

// ### wcp_pulse_timer.sv
// Cleaning pulse timer: (code+1) x 64 us active window
`timescale 1ns/1ps
`default_nettype none

module wcp_pulse_timer
  import wcp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  input  wire logic [2:0]  duration_code,
  // Status
  output logic             active
);

  logic [CNT_W-1:0] step_reg;
  logic [2:0]       steps_left_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      active         <= 1'b0;
      step_reg       <= '0;
      steps_left_reg <= '0;
    end
    else if (start && !active)
    begin
      active         <= 1'b1;
      step_reg       <= CNT_W'(STEP_CYCLES - 1);
      steps_left_reg <= duration_code;
    end
    else if (active)
    begin
      if (step_reg != '0)
        step_reg <= step_reg - 1'b1;
      else if (steps_left_reg != '0)
      begin
        step_reg       <= CNT_W'(STEP_CYCLES - 1);
        steps_left_reg <= steps_left_reg - 1'b1;
      end
      else
        active <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### wcp_bank.sv
// APB register bank for wetting current and cleaning pulse settings
`timescale 1ns/1ps
`default_nettype none

module wcp_bank
  import wcp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse trigger from the scan sequencer
  input  wire logic        pulse_start,
  // Current source controls
  output logic      [15:0] pair_level_ma,
  output logic      [15:0] pulse_level_ma,
  output logic      [23:0] pulse_drive,
  output logic             pulse_busy
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [REG_W-1:0] wetting_current_select_hi_reg;
  logic [REG_W-1:0] pulse_time_current_config_reg;
  logic [REG_W-1:0] pulse_input_enable_reg;
  logic             start_sync1_reg;
  logic             start_sync2_reg;
  logic             timer_active;
  logic [15:0]      pair_level_next;
  logic [15:0]      pulse_level_next;
  logic [23:0]      pulse_drive_next;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic             access;
  logic             hit_wc;
  logic             hit_cfg;
  logic             hit_en;
  logic             hit_any;
  logic             wr_ok;
  logic [31:0]      rdata_next;

  assign access  = psel && penable && !pready;
  assign hit_wc  = (paddr[ADDR_W-1:0] == WC_SELECT_HI_ADDR)
                   && (paddr[31:ADDR_W] == '0);
  assign hit_cfg = (paddr[ADDR_W-1:0] == PULSE_CFG_ADDR)
                   && (paddr[31:ADDR_W] == '0);
  assign hit_en  = (paddr[ADDR_W-1:0] == PULSE_EN_ADDR)
                   && (paddr[31:ADDR_W] == '0);
  assign hit_any = hit_wc || hit_cfg || hit_en;
  assign wr_ok   = access && pwrite && hit_any;

  always_comb
  begin
    rdata_next = '0;
    if (hit_wc)
      rdata_next = {8'h00, wetting_current_select_hi_reg};
    else if (hit_cfg)
      rdata_next = {8'h00, pulse_time_current_config_reg};
    else if (hit_en)
      rdata_next = {8'h00, pulse_input_enable_reg};
  end

  // One wait state: answer in the cycle after the first access cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && !hit_any;
      prdata  <= (access && !pwrite) ? rdata_next : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      wetting_current_select_hi_reg <= REG_RESET;
    else if (wr_ok && hit_wc)
      wetting_current_select_hi_reg <= pwdata[REG_W-1:0]
                                       & WC_WRITE_MASK;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      pulse_time_current_config_reg <= REG_RESET;
    else if (wr_ok && hit_cfg)
      pulse_time_current_config_reg <= pwdata[REG_W-1:0]
                                       & PULSE_CFG_MASK;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      pulse_input_enable_reg <= REG_RESET;
    else if (wr_ok && hit_en)
      pulse_input_enable_reg <= pwdata[REG_W-1:0]
                                & PULSE_EN_MASK;
  end

  // ----------------------------------------------------------------------
  // Pulse trigger synchroniser and timer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start_sync1_reg <= 1'b0;
      start_sync2_reg <= 1'b0;
    end
    else
    begin
      start_sync1_reg <= pulse_start;
      start_sync2_reg <= start_sync1_reg;
    end
  end

  wcp_pulse_timer u_timer
  (
    .mclk          (mclk),
    .rst           (rst),
    .start         (start_sync2_reg),
    .duration_code (pulse_time_current_config_reg[DUR_MSB:DUR_LSB]),
    .active        (timer_active)
  );

  // ----------------------------------------------------------------------
  // Current decoding per pair and per pulse group
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi++)
    begin : g_pair
      wcp_current_decode u_dec
      (
        .code     (wetting_current_select_hi_reg[gi*CODE_W +: CODE_W]),
        .level_ma (pair_level_next[gi*4 +: 4])
      );
    end
    for (gi = 0; gi < NUM_GROUPS; gi++)
    begin : g_group
      // Group 0 is inputs 0-5, up to group 3 for inputs 18-23
      assign pulse_level_next[gi*4 +: 4] =
        pulse_time_current_config_reg[LEVEL_LSB + gi] ? MA_15 : MA_10;
    end
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_drive
      assign pulse_drive_next[gi] = timer_active
                                    && pulse_input_enable_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pair_level_ma  <= '0;
      pulse_level_ma <= '0;
      pulse_drive    <= '0;
      pulse_busy     <= 1'b0;
    end
    else
    begin
      pair_level_ma  <= pair_level_next;
      pulse_level_ma <= pulse_level_next;
      pulse_drive    <= pulse_drive_next;
      pulse_busy     <= timer_active;
    end
  end

endmodule

`default_nettype wire

// ### wcp_bank_monitor.sv
// Checker for the wetting current and cleaning pulse register bank
`timescale 1ns/1ps
`default_nettype none

module wcp_bank_monitor
  import wcp_pkg::*;
(
  // Clock, reset and bus
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pulse and current controls
  input wire logic        pulse_start,
  input wire logic [15:0] pair_level_ma,
  input wire logic [15:0] pulse_level_ma,
  input wire logic [23:0] pulse_drive,
  input wire logic        pulse_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire logic acc = psel && penable && !pready;
  wire logic hit = paddr inside {32'h0000_0078, 32'h0000_007c, 32'h0000_0080};

  function automatic bit lv(input logic [3:0] n);
    return n inside {4'h0, 4'h1, 4'h2, 4'h5, 4'ha, 4'hf};
  endfunction

  // Pulse group level is either 10 mA or 15 mA
  function automatic bit lg(input logic [3:0] n);
    return n inside {4'ha, 4'hf};
  endfunction

  sequence s_go;
    $rose(pulse_start) && !pulse_busy;
  endsequence
  sequence s_on;
    ##[1:6] $rose(pulse_busy);
  endsequence

  a_ready_one_wait: assert property (acc |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (acc && !hit |=> pslverr && prdata == '0)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (acc && hit |=> !pslverr)
    else $error("mapped access refused");
  a_cfg_reserved: assert property (pready && !pwrite && paddr == 32'h0000_007c
    |-> prdata[31:7] == '0)
    else $error("reserved bits not zero");
  a_pair_legal: assert property (lv(pair_level_ma[3:0]) && lv(pair_level_ma[7:4])
    && lv(pair_level_ma[11:8]) && lv(pair_level_ma[15:12]))
    else $error("illegal pair level");
  a_group_level: assert property (!$past(rst) |->
    lg(pulse_level_ma[3:0]) && lg(pulse_level_ma[7:4])
    && lg(pulse_level_ma[11:8]) && lg(pulse_level_ma[15:12]))
    else $error("illegal pulse level");
  a_drive_busy: assert property (pulse_drive != '0 |-> pulse_busy)
    else $error("drive outside window");
  a_busy_start: assert property (s_go |-> s_on)
    else $error("pulse did not start");
  a_busy_hold: assert property ($rose(pulse_busy) |-> pulse_busy [*8])
    else $error("pulse window too short");
endmodule

bind wcp_bank wcp_bank_monitor wcp_bank_monitor_inst (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_start(pulse_start), .pair_level_ma(pair_level_ma),
  .pulse_level_ma(pulse_level_ma), .pulse_drive(pulse_drive),
  .pulse_busy(pulse_busy));

`default_nettype wire

// ### wcp_bank_tb.sv
// Testbench for the wetting current and cleaning pulse register bank
`timescale 1ns/1ps
`default_nettype none

module wcp_bank_tb
  import wcp_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        pulse_start = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, pulse_busy, err;
  logic [15:0] pair_level_ma, pulse_level_ma;
  logic [23:0] pulse_drive;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n;
  localparam logic [31:0] A_WC = {22'h0, WC_SELECT_HI_ADDR};
  localparam logic [31:0] A_CF = {22'h0, PULSE_CFG_ADDR};
  localparam logic [31:0] A_EN = {22'h0, PULSE_EN_ADDR};
  logic [11:0] wc_val [2] = '{12'h688, 12'hfac};
  logic [31:0] cf_val [3] = '{32'hffff_ffff, 32'h0000_0005, 32'h0000_0010};
  logic [15:0] cf_lvl [3] = '{16'hffff, 16'hafaf, 16'haaaa};

  always #25 mclk = ~mclk;

  wcp_bank wcp_bank_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_start(pulse_start), .pair_level_ma(pair_level_ma),
    .pulse_level_ma(pulse_level_ma), .pulse_drive(pulse_drive),
    .pulse_busy(pulse_busy));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic [3:0] ma(input logic [2:0] c);
    case (c)
      3'h0, 3'h1, 3'h2: return {1'b0, c};
      3'h3: return 4'h5;
      3'h4: return 4'ha;
      default: return 4'hf;
    endcase
  endfunction

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    tally_and_finish;
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, A_CF, 32'h0);
    chk("cfg reset", rd, 32'h0);
    apb(1'b0, A_EN, 32'h0);
    chk("enable reset", rd, 32'h0);
    chk("level reset", pulse_level_ma, 32'h0000_aaaa);
    foreach (wc_val[i])
    begin
      apb(1'b1, A_WC, {20'hfffff, wc_val[i]});
      apb(1'b0, A_WC, 32'h0);
      chk("pair codes", rd, {20'h0, wc_val[i]});
      chk("pair mA", pair_level_ma, {ma(wc_val[i][11:9]), ma(wc_val[i][8:6]),
        ma(wc_val[i][5:3]), ma(wc_val[i][2:0])});
    end
    foreach (cf_val[i])
    begin
      apb(1'b1, A_CF, cf_val[i]);
      apb(1'b0, A_CF, 32'h0);
      chk("cfg read", rd, cf_val[i] & 32'h0000_007f);
      chk("group mA", pulse_level_ma, cf_lvl[i]);
    end
    apb(1'b1, A_EN, 32'hffa5_5a5a);
    apb(1'b0, A_EN, 32'h0);
    chk("enable read", rd, 32'h00a5_5a5a);
    chk("mapped err", err, 1'b0);
    apb(1'b0, 32'h0000_0084, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    // Duration code 1 gives two 64 us steps of 1280 cycles
    pulse_start <= 1'b1;
    n = 0;
    while (pulse_busy !== 1'b1 && n < 10)
    begin
      @(posedge mclk);
      n++;
    end
    pulse_start <= 1'b0;
    chk("drive on", pulse_drive, 32'h00a5_5a5a);
    n = 0;
    while (pulse_busy === 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    chk("pulse length", n, 2 * 1280);
    chk("drive off", pulse_drive, 32'h0);
    tally_and_finish;
  end
endmodule

`default_nettype wire
